// >>> src/isp_pkg.sv
// isp_pkg: register map, field layouts, mode codes and decode helpers of the i2c slave port
// assumes an apb master with 32-bit data and byte addresses, and one 50 mhz system clock
package isp_pkg;
	localparam int AW = 8;
	// register byte addresses
	localparam logic [AW-1:0] OFF_CTL = 8'h00;
	localparam logic [AW-1:0] OFF_BUF = 8'h04;
	localparam logic [AW-1:0] OFF_ADR = 8'h08;
	localparam logic [AW-1:0] OFF_STAT = 8'h0c;
	localparam logic [AW-1:0] OFF_IST = 8'h10;
	localparam logic [AW-1:0] OFF_IMSK = 8'h14;
	localparam logic [AW-1:0] OFF_PIN = 8'h18;
	// mode_select codes
	localparam logic [3:0] MODE_SLV7 = 4'h6;
	localparam logic [3:0] MODE_SLV10 = 4'h7;
	localparam logic [3:0] MODE_MASK = 4'h9;
	localparam logic [3:0] MODE_FWM = 4'hb;
	localparam logic [3:0] MODE_SLV7SS = 4'he;
	localparam logic [3:0] MODE_SLV10SS = 4'hf;
	// reset values
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] ADR_RST = 8'h00;
	localparam logic [7:0] MSK_RST = 8'hff;
	localparam logic [1:0] PIN_RST = 2'h0;
	// address and bit counting
	localparam logic [4:0] HDR10 = 5'h1e;
	localparam logic [7:0] ADR7_BITS = 8'hfe;
	localparam logic [7:0] IDLE_BYTE = 8'hff;
	localparam logic [3:0] FIRST_BIT = 4'h0;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] PRE_BIT = 4'hf; // between a start and its scl fall
	// interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_BYTE = 0;
	localparam int IRQ_START = 1;
	localparam int IRQ_STOP = 2;

	typedef struct packed {
		logic write_collision_flag;
		logic receive_overflow_flag;
		logic port_enable;
		logic clock_hold_release;
		logic [3:0] mode_select;
	} isp_ctl_t;

	typedef struct packed {
		logic stop_seen;
		logic start_seen;
		logic read_req;
		logic data_byte;
		logic address_update_needed;
		logic buffer_full;
	} isp_stat_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_ADDR2 = 5'h04,
		ST_RX = 5'h08,
		ST_TX = 5'h10
	} isp_phase_t;

	typedef struct packed {
		isp_ctl_t ctl;
		logic [7:0] shift_buffer;
		logic [7:0] slave_address_reg;
		logic [7:0] address_mask_reg;
		logic [7:0] shreg;
		logic [3:0] bitcnt;
		isp_phase_t phase;
		isp_stat_t stat;
		logic update_pend;
		logic ack_drv;
		logic master_nack;
		logic hold;
		logic hi_match;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [1:0] pin_low;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		logic apb_done;
		logic [31:0] prdata;
	} isp_state_t;

	localparam isp_state_t ISP_RST = '{ctl: isp_ctl_t'(CTL_RST), slave_address_reg: ADR_RST,
		address_mask_reg: MSK_RST, shreg: IDLE_BYTE, phase: ST_IDLE, pin_low: PIN_RST,
		scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'h1, sda_d: 1'h1, default: '0};

	function automatic logic isp_is_slave(input logic [3:0] m);
		return m == MODE_SLV7 || m == MODE_SLV10 || m == MODE_SLV7SS || m == MODE_SLV10SS;
	endfunction : isp_is_slave

	function automatic logic isp_is_10bit(input logic [3:0] m);
		return m == MODE_SLV10 || m == MODE_SLV10SS;
	endfunction : isp_is_10bit

	function automatic logic isp_ss_irq(input logic [3:0] m);
		return m == MODE_FWM || m == MODE_SLV7SS || m == MODE_SLV10SS;
	endfunction : isp_ss_irq

	function automatic logic isp_match(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
		return ((b ^ a) & m) == 8'h00;
	endfunction : isp_match

	function automatic logic isp_mapped(input logic [AW-1:0] a);
		return a == OFF_CTL || a == OFF_BUF || a == OFF_ADR || a == OFF_STAT
			|| a == OFF_IST || a == OFF_IMSK || a == OFF_PIN;
	endfunction : isp_mapped
endpackage : isp_pkg

// >>> src/isp_i2c_port.sv
// isp_i2c_port: i2c slave serial port with clock hold, apb registers and interrupt
// assumes open-drain scl/sda resolved outside; pins are asynchronous and synchronised here
//
// Overview of operation
// - with clock hold active, pull scl low only after scl was sampled low
// - keep scl low until hold released by software and the bus lets scl rise
// - keep receiving in sleep; wake on address match or byte if enabled
// - writing the buffer during transmission sets write collision flag until cleared
// - byte arriving while buffer still full sets receive overflow flag
// - receive overflow flag clears only by software writing zero
// - port enable hands sda and scl to the port, honouring pin drive settings
// - port disable stops the port and returns pins to plain pin control
// - clock hold release one frees scl, zero stretches scl low
// - mode 0111 is slave with 10-bit address matching
// - mode 1001 redirects slave address register accesses to the mask register
// - mode 1011 idles slave logic, start and stop detection remain
// - hardware clearing clock hold release stretches scl until software sets it
// - 10-bit address bytes stretch scl until address written, flagging update needed
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module isp_i2c_port (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [isp_pkg::AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic sleep,
	output logic irq,
	output logic wake
);
	isp_pkg::isp_state_t r;
	isp_pkg::isp_state_t next_r;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic slave_on;
	logic ten;
	logic ss_irq;
	logic mask_sel;
	logic apb_access;
	logic wr_go;
	logic rd_go;
	logic tx_busy;
	logic sda_slave;
	logic [7:0] rd_byte;

	// accept a received byte, or flag overflow and withhold the ack
	function automatic isp_pkg::isp_state_t isp_take(input isp_pkg::isp_state_t v,
		input isp_pkg::isp_state_t old);
		isp_pkg::isp_state_t t;
		t = v;
		if (old.stat.buffer_full) begin
			t.ctl.receive_overflow_flag = 1'b1;
		end else begin
			t.shift_buffer = old.shreg;
			t.stat.buffer_full = 1'b1;
			t.ack_drv = 1'b1;
		end
		return t;
	endfunction : isp_take

	// bus levels after two-flop synchronisers, edges against the previous sample
	assign scl = r.scl_s[1];
	assign sda = r.sda_s[1];
	assign scl_rise = scl & ~r.scl_d;
	assign scl_fall = ~scl & r.scl_d;
	assign start_cond = scl & r.scl_d & r.sda_d & ~sda;
	assign stop_cond = scl & r.scl_d & ~r.sda_d & sda;

	// mode decode
	assign slave_on = r.ctl.port_enable & isp_pkg::isp_is_slave(r.ctl.mode_select);
	assign ten = isp_pkg::isp_is_10bit(r.ctl.mode_select);
	assign ss_irq = isp_pkg::isp_ss_irq(r.ctl.mode_select);
	assign mask_sel = r.ctl.mode_select == isp_pkg::MODE_MASK;

	// apb: two-cycle access phase, effects land on the pready edge
	assign apb_access = psel & penable;
	assign wr_go = apb_access & pwrite & r.apb_done;
	assign rd_go = apb_access & ~pwrite & r.apb_done;
	assign pready = r.apb_done;
	assign pslverr = r.apb_done & ~isp_pkg::isp_mapped(paddr);
	assign prdata = r.prdata;

	// transmitting means released clock with data bits still to go
	assign tx_busy = r.phase == isp_pkg::ST_TX && r.ctl.clock_hold_release && r.bitcnt <= isp_pkg::LAST_BIT;
	assign sda_slave = r.ack_drv | (r.phase == isp_pkg::ST_TX && r.bitcnt <= isp_pkg::LAST_BIT && ~r.shreg[7]);

	// open drain: outputs only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = r.pin_low[0] | (r.ctl.port_enable & r.hold);
	assign sda_oe = r.pin_low[1] | (r.ctl.port_enable & sda_slave);

	// no clock gating in sleep, so the bus logic keeps running
	assign irq = |(r.irq_status & r.irq_mask);
	assign wake = sleep & irq;

	// read mux
	always_comb begin
		if (paddr == isp_pkg::OFF_CTL) begin
			rd_byte = r.ctl;
		end else if (paddr == isp_pkg::OFF_BUF) begin
			rd_byte = r.shift_buffer;
		end else if (paddr == isp_pkg::OFF_ADR) begin
			rd_byte = mask_sel ? r.address_mask_reg : r.slave_address_reg;
		end else if (paddr == isp_pkg::OFF_STAT) begin
			rd_byte = {scl, sda, r.stat};
		end else if (paddr == isp_pkg::OFF_IST) begin
			rd_byte = {{(8 - isp_pkg::IRQ_W){1'b0}}, r.irq_status};
		end else if (paddr == isp_pkg::OFF_IMSK) begin
			rd_byte = {{(8 - isp_pkg::IRQ_W){1'b0}}, r.irq_mask};
		end else if (paddr == isp_pkg::OFF_PIN) begin
			rd_byte = {6'h00, r.pin_low};
		end else begin
			rd_byte = 8'h00;
		end
	end

	// next state: software first, hardware events after so a hardware update beats a software write
	always_comb begin
		next_r = r;
		next_r.scl_s = {r.scl_s[0], scl_in};
		next_r.sda_s = {r.sda_s[0], sda_in};
		next_r.scl_d = scl;
		next_r.sda_d = sda;
		next_r.apb_done = apb_access & ~r.apb_done;
		if (apb_access & ~r.apb_done) begin
			next_r.prdata = {24'h000000, rd_byte};
		end

		// register writes
		if (wr_go) begin
			if (paddr == isp_pkg::OFF_CTL) begin
				next_r.ctl = isp_pkg::isp_ctl_t'(pwdata[7:0]);
			end else if (paddr == isp_pkg::OFF_BUF) begin
				if (tx_busy) begin
					next_r.ctl.write_collision_flag = 1'b1;
				end else begin
					next_r.shift_buffer = pwdata[7:0];
					if (r.phase == isp_pkg::ST_TX && r.bitcnt == isp_pkg::FIRST_BIT) begin
						next_r.shreg = pwdata[7:0];
						next_r.stat.buffer_full = 1'b1;
					end
				end
			end else if (paddr == isp_pkg::OFF_ADR) begin
				if (mask_sel) begin
					next_r.address_mask_reg = pwdata[7:0];
				end else begin
					next_r.slave_address_reg = pwdata[7:0];
					next_r.stat.address_update_needed = 1'b0;
				end
			end else if (paddr == isp_pkg::OFF_IST) begin
				next_r.irq_status = r.irq_status & ~pwdata[isp_pkg::IRQ_W-1:0];
			end else if (paddr == isp_pkg::OFF_IMSK) begin
				next_r.irq_mask = pwdata[isp_pkg::IRQ_W-1:0];
			end else if (paddr == isp_pkg::OFF_PIN) begin
				next_r.pin_low = pwdata[1:0];
			end
		end
		if (rd_go && paddr == isp_pkg::OFF_BUF) begin
			next_r.stat.buffer_full = 1'b0;
		end

		// bus conditions and byte sequencing
		if (!r.ctl.port_enable) begin
			next_r.phase = isp_pkg::ST_IDLE;
			next_r.bitcnt = isp_pkg::FIRST_BIT;
			next_r.ack_drv = 1'b0;
			next_r.stat.start_seen = 1'b0;
			next_r.stat.stop_seen = 1'b0;
			next_r.hi_match = 1'b0;
			next_r.update_pend = 1'b0;
		end else if (start_cond) begin
			next_r.stat.start_seen = 1'b1;
			next_r.stat.stop_seen = 1'b0;
			if (ss_irq) begin
				next_r.irq_status[isp_pkg::IRQ_START] = 1'b1;
			end
			next_r.phase = slave_on ? isp_pkg::ST_ADDR : isp_pkg::ST_IDLE;
			next_r.bitcnt = isp_pkg::PRE_BIT;
			next_r.ack_drv = 1'b0;
		end else if (stop_cond) begin
			next_r.stat.stop_seen = 1'b1;
			next_r.stat.start_seen = 1'b0;
			if (ss_irq) begin
				next_r.irq_status[isp_pkg::IRQ_STOP] = 1'b1;
			end
			next_r.phase = isp_pkg::ST_IDLE;
			next_r.bitcnt = isp_pkg::FIRST_BIT;
			next_r.ack_drv = 1'b0;
			next_r.hi_match = 1'b0;
		end else if (slave_on && r.phase != isp_pkg::ST_IDLE) begin
			// sample on rising scl: data bits in, or the master's ack after a sent byte
			if (scl_rise) begin
				if (r.bitcnt == isp_pkg::ACK_BIT) begin
					next_r.master_nack = sda;
				end else if (r.phase != isp_pkg::ST_TX) begin
					next_r.shreg = {r.shreg[6:0], sda};
				end
			end
			// falling scl advances the bit count
			if (scl_fall) begin
				if (r.bitcnt == isp_pkg::PRE_BIT) begin
					// the fall closing a start carries no bit, else the address would be one short
					next_r.bitcnt = isp_pkg::FIRST_BIT;
				end else if (r.bitcnt < isp_pkg::LAST_BIT) begin
					next_r.bitcnt = r.bitcnt + 4'h1;
					if (r.phase == isp_pkg::ST_TX) begin
						next_r.shreg = {r.shreg[6:0], 1'b1};
					end
				end else if (r.bitcnt == isp_pkg::LAST_BIT) begin
					// eighth falling edge: decide the ack
					next_r.bitcnt = isp_pkg::ACK_BIT;
					case (r.phase)
						isp_pkg::ST_ADDR: begin
							next_r.stat.data_byte = 1'b0;
							next_r.stat.read_req = r.shreg[0];
							if (!isp_pkg::isp_match(r.shreg, r.slave_address_reg,
								r.address_mask_reg & isp_pkg::ADR7_BITS)
								|| (ten && r.shreg[7:3] != isp_pkg::HDR10)) begin
								next_r.phase = isp_pkg::ST_IDLE;
							end else if (r.shreg[0]) begin
								// a 10-bit read needs the full address matched earlier
								if (ten && !r.hi_match) begin
									next_r.phase = isp_pkg::ST_IDLE;
								end else begin
									next_r.phase = isp_pkg::ST_TX;
									next_r.ack_drv = 1'b1;
								end
							end else begin
								next_r = isp_take(next_r, r);
								next_r.phase = ten ? isp_pkg::ST_ADDR2 : isp_pkg::ST_RX;
								next_r.update_pend = ten;
							end
						end
						isp_pkg::ST_ADDR2: begin
							if (isp_pkg::isp_match(r.shreg, r.slave_address_reg, r.address_mask_reg)) begin
								next_r = isp_take(next_r, r);
								next_r.phase = isp_pkg::ST_RX;
								next_r.update_pend = 1'b1;
								next_r.hi_match = 1'b1;
							end else begin
								next_r.phase = isp_pkg::ST_IDLE;
							end
						end
						isp_pkg::ST_RX: begin
							next_r = isp_take(next_r, r);
							next_r.stat.data_byte = 1'b1;
						end
						isp_pkg::ST_TX: begin
							next_r.stat.buffer_full = 1'b0;
							next_r.stat.data_byte = 1'b1;
						end
						default: begin
						end
					endcase
				end else begin
					// ninth falling edge: end of byte, raise the interrupt for a sent or acked byte
					next_r.bitcnt = isp_pkg::FIRST_BIT;
					next_r.ack_drv = 1'b0;
					next_r.update_pend = 1'b0;
					if (r.update_pend) begin
						next_r.stat.address_update_needed = 1'b1;
					end
					if (r.phase == isp_pkg::ST_TX) begin
						next_r.irq_status[isp_pkg::IRQ_BYTE] = 1'b1;
						if (r.master_nack) begin
							next_r.phase = isp_pkg::ST_IDLE;
						end else begin
							next_r.ctl.clock_hold_release = 1'b0;
							next_r.shreg = isp_pkg::IDLE_BYTE;
						end
					end else if (r.ack_drv) begin
						next_r.irq_status[isp_pkg::IRQ_BYTE] = 1'b1;
					end
				end
			end
		end

		// clock stretch: grab scl only once it is already low, let go on release
		if (!r.ctl.port_enable) begin
			next_r.hold = 1'b0;
		end else if ((~r.ctl.clock_hold_release | r.stat.address_update_needed) & ~scl) begin
			next_r.hold = 1'b1;
		end else if (r.ctl.clock_hold_release & ~r.stat.address_update_needed) begin
			next_r.hold = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= isp_pkg::ISP_RST;
		end else begin
			r <= next_r;
		end
	end
endmodule : isp_i2c_port

// >>> bench/isp_port_props.sv
// isp_port_props: concurrent checks on the pins and apb port of the i2c slave port
// assumes one clock domain and a write that takes effect at the edge where pready is high
`timescale 1ns/100ps
module isp_port_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [isp_pkg::AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic scl_in,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic sleep,
	input wire logic irq,
	input wire logic wake
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// completed apb writes; the pin register is never used here, so enable alone decides
	logic wr_done;
	logic ctl_wr;
	assign wr_done = psel && penable && pready && pwrite;
	assign ctl_wr = wr_done && paddr == isp_pkg::OFF_CTL;
	// stretch only after the line was already low, so no high phase is cut short
	property p_hold_after_low;
		$rose(scl_oe) |-> !$past(scl_in, 3); // two synchroniser flops plus the hold flop
	endproperty
	a_hold_after_low: assert property (p_hold_after_low) else $error("scl pulled while high");
	property p_release_on_write;
		$fell(scl_oe) |-> $past(wr_done) || $past(wr_done, 2); // disable frees at once, a release a cycle later
	endproperty
	a_release_on_write: assert property (p_release_on_write) else $error("scl freed without write");
	property p_hold_kept;
		scl_oe && !(psel && penable && pwrite) && !$past(wr_done) |=> scl_oe;
	endproperty
	a_hold_kept: assert property (p_hold_kept) else $error("scl hold dropped");
	property p_wake_level;
		wake == (sleep && irq);
	endproperty
	a_wake_level: assert property (p_wake_level) else $error("wake mismatch");
	property p_disable_frees;
		ctl_wr && !pwdata[5] |=> !scl_oe && !sda_oe;
	endproperty
	a_disable_frees: assert property (p_disable_frees) else $error("pins driven while off");
	property p_release_bit;
		ctl_wr && pwdata[5:4] == 2'b11 |-> ##2 !scl_oe;
	endproperty
	a_release_bit: assert property (p_release_bit) else $error("scl kept after release");
	property p_reset_quiet;
		$rose(rst_b) |-> !scl_oe && !sda_oe && !irq;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	// ack changes only during scl low
	property p_sda_low_phase;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_sda_low_phase: assert property (p_sda_low_phase) else $error("sda moved while scl high");
	c_stretch: cover property ($rose(scl_oe));
	c_wake: cover property ($rose(wake));
	c_ack: cover property ($rose(sda_oe));
endmodule : isp_port_props
bind isp_i2c_port isp_port_props u_props (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
	.scl_in, .scl_oe, .sda_oe, .sleep, .irq, .wake);

// >>> bench/isp_i2c_master.sv
// isp_i2c_master: behavioural i2c bus master, 160 ns bit period, honours clock stretching
// assumes pulled-up open-drain lines resolved by the bench; oe high pulls a line low
`timescale 1ns/100ps
module isp_i2c_master (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// half a link period is four system clocks
	task automatic half;
		repeat (4) @(posedge clk);
	endtask : half
	// release scl, wait while any device stretches, bounded, then four clocks high
	task automatic rise;
		int n;
		n = 0;
		scl_oe <= 1'b0;
		@(posedge clk);
		while (scl !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
	endtask : rise
	// one bit: data changes mid low phase, line sampled at the end of the high phase
	task automatic clock_bit(input logic v, output logic seen);
		scl_oe <= 1'b1;
		repeat (2) @(posedge clk);
		sda_oe <= ~v;
		repeat (2) @(posedge clk);
		rise();
		seen = sda;
	endtask : clock_bit
	task automatic start;
		sda_oe <= 1'b1;
		half();
		scl_oe <= 1'b1;
		half();
	endtask : start
	task automatic stop;
		sda_oe <= 1'b1;
		half();
		rise();
		sda_oe <= 1'b0;
		half();
	endtask : stop
	// msb first, then release sda and sample the ack while scl high
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], s);
		end
		clock_bit(1'b1, s);
		ack = ~s;
		scl_oe <= 1'b1;
		half();
	endtask : send
	// slave drives the byte; nack high ends the read
	task automatic recv(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, s);
			d[i] = s;
		end
		clock_bit(nack, s);
		scl_oe <= 1'b1;
		half();
	endtask : recv
endmodule : isp_i2c_master

// >>> bench/isp_i2c_port_tb_top.sv
// isp_i2c_port_tb_top: register and bus-level tests of the i2c slave port
// assumes the partner master isp_i2c_master on pulled-up open-drain lines
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			n_errors++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end
module isp_i2c_port_tb_top;
	logic clk, rst_b, psel, penable, pwrite, sleep, pready, pslverr, irq, wake, ack, err;
	logic scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
	logic [isp_pkg::AW-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] rx_byte;
	int n_errors, n_tests, cyc;
	logic [7:0] ctl_seq [4] = '{8'h26, 8'h36, 8'h26, 8'h06};
	logic oe_seq [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	// open-drain lines with pull-ups
	wire scl = ~(scl_oe | m_scl_oe);
	wire sda = ~(sda_oe | m_sda_oe);
	isp_i2c_port u_dut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .sleep(sleep), .irq(irq), .wake(wake));
	isp_i2c_master u_mst (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= {24'h000000, d};
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20) begin
			n_errors++;
			end_of_test();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		apb(1'b0, a, 8'h00);
		`CHK($sformatf("register %h", a), {24'h000000, d}, q)
	endtask : rd
	// bounded wait for the clock hold output to settle
	task automatic oe_is(input logic e);
		int n;
		n = 0;
		while (scl_oe !== e && n < 20) begin
			@(posedge clk);
			n++;
		end
		`CHK("scl hold", e, scl_oe)
	endtask : oe_is
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		sleep = 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(isp_pkg::OFF_CTL, 8'h00);
		rd(isp_pkg::OFF_ADR, 8'h00);
		apb(1'b0, 8'h1c, 8'h00);
		`CHK("slave error", 1'b1, err)
		// mask register reached through the address location
		apb(1'b1, isp_pkg::OFF_CTL, 8'h09);
		rd(isp_pkg::OFF_ADR, 8'hff);
		apb(1'b1, isp_pkg::OFF_ADR, 8'hfe);
		apb(1'b1, isp_pkg::OFF_CTL, 8'h06);
		rd(isp_pkg::OFF_ADR, 8'h00);
		// hold, release, re-hold on a low line, then disable
		u_mst.start();
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, isp_pkg::OFF_CTL, ctl_seq[i]);
			oe_is(oe_seq[i]);
		end
		u_mst.stop();
		// 7-bit receive in sleep, then overflow on an unread buffer
		apb(1'b1, isp_pkg::OFF_ADR, 8'ha4);
		apb(1'b1, isp_pkg::OFF_IMSK, 8'h01);
		apb(1'b1, isp_pkg::OFF_CTL, 8'h36);
		sleep <= 1'b1;
		u_mst.start();
		u_mst.send(8'ha4, ack);
		`CHK("address ack", 1'b1, ack)
		rd(isp_pkg::OFF_IST, 8'h01);
		`CHK("wake", 1'b1, wake)
		apb(1'b1, isp_pkg::OFF_IMSK, 8'h00);
		`CHK("masked irq", 1'b0, irq)
		apb(1'b1, isp_pkg::OFF_IMSK, 8'h01);
		`CHK("irq", 1'b1, irq)
		u_mst.send(8'h3c, ack);
		`CHK("overflow ack", 1'b0, ack)
		rd(isp_pkg::OFF_CTL, 8'h76);
		u_mst.stop();
		rd(isp_pkg::OFF_CTL, 8'h76);
		rd(isp_pkg::OFF_BUF, 8'ha4);
		apb(1'b1, isp_pkg::OFF_IST, 8'h07);
		`CHK("cleared wake", 1'b0, wake)
		apb(1'b1, isp_pkg::OFF_CTL, 8'h36);
		rd(isp_pkg::OFF_CTL, 8'h36);
		sleep <= 1'b0;
		// 7-bit read: hardware drops the hold bit, software reloads and releases
		u_mst.start();
		u_mst.send(8'ha5, ack);
		`CHK("read ack", 1'b1, ack)
		oe_is(1'b1);
		apb(1'b1, isp_pkg::OFF_BUF, 8'h5c);
		apb(1'b1, isp_pkg::OFF_CTL, 8'h36);
		oe_is(1'b0);
		apb(1'b1, isp_pkg::OFF_BUF, 8'h11);
		rd(isp_pkg::OFF_CTL, 8'hb6);
		u_mst.recv(1'b1, rx_byte);
		`CHK("sent byte", 8'h5c, rx_byte)
		u_mst.stop();
		// firmware master mode: no ack, start and stop still seen
		apb(1'b1, isp_pkg::OFF_CTL, 8'h3b);
		u_mst.start();
		u_mst.send(8'ha4, ack);
		`CHK("idle ack", 1'b0, ack)
		u_mst.stop();
		apb(1'b0, isp_pkg::OFF_IST, 8'h00);
		`CHK("start stop seen", 2'b11, q[2:1])
		// 10-bit header stretches until the address is rewritten
		apb(1'b1, isp_pkg::OFF_CTL, 8'h37);
		apb(1'b1, isp_pkg::OFF_ADR, 8'hf2);
		u_mst.start();
		u_mst.send(8'hf2, ack);
		`CHK("header ack", 1'b1, ack)
		apb(1'b0, isp_pkg::OFF_STAT, 8'h00);
		`CHK("update needed", 1'b1, q[1])
		oe_is(1'b1);
		apb(1'b1, isp_pkg::OFF_ADR, 8'h5a);
		oe_is(1'b0);
		u_mst.stop();
		end_of_test();
	end
endmodule : isp_i2c_port_tb_top
